// ### core/mtp_thermal_protect.sv
// electronic motor thermal overload protection with second motor set
// assumes currents and frequency are synchronous to sys_clk_i, terminals already debounced
`timescale 1ns/100ps
`include "mtp_consts.svh"

// ==========================================================
// leaky heat integrator, one per motor and one for the output stage
module mtp_heat_acc (
    input wire logic sys_clk_i, // control clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic tick_i, // integration step pulse
    input wire logic enable_i, // function active
    input wire logic [27:0] heat_i, // squared current, zero when cooling
    output logic [27:0] acc_o // thermal accumulator
);
    logic [27:0] acc_r;
    logic [27:0] rise;
    logic [27:0] fall;
    logic [27:0] acc_nxt;

    // first order model: the accumulator creeps toward the heat input
    assign rise = (heat_i - acc_r) >> `MTP_LEAK_SHIFT;
    assign fall = (acc_r - heat_i) >> `MTP_LEAK_SHIFT;
    assign acc_nxt = !enable_i ? 28'h0 :
                     !tick_i ? acc_r :
                     (heat_i >= acc_r) ? acc_r + rise : acc_r - fall;

    // cleared only by reset or when the function is switched off
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_r <= 28'h0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    assign acc_o = acc_r;
endmodule // mtp_heat_acc

// What this block does
// - first rated current accepts 0 to 500 A and references motor one integration
// - first rated current zero disables motor one protection, output stage still protected
// - second rated current 9999 disables motor two; 0 to 500 A sets it
// - second-function select switches protection to the second rated current
// - the selected valid motor integrates the measured output current
// - a valid unselected motor integrates zero current so it cools
// - a motor set to zero or 9999 stays inactive whatever the select
// - at 85 percent of rated level assert prealarm output and indication
// - at 100 percent of rated level trip with motor overload fault code
// - prealarm alone never trips or stops the output
// - output terminal code 8 gives prealarm active high, 108 active low
// - second-function select comes from input terminals coded 3
// - external thermal relay input comes from input terminals coded 7
// - external relay operating trips with the external thermal fault code
// - latched faults clear only by reset or power cycle
// - first rated current defaults to drive rating, 85 percent for small ratings
// - constant-torque curve applies only at 6 Hz and above
// - higher carrier frequency shortens output stage protection time
// - second-function select also enables the drive's other second-set functions
// - second motor type 9999 means no second motor, first characteristic applies
module mtp_thermal_protect #(
    parameter logic [15:0] DRIVE_RATED_CURRENT = 16'h00A0, // drive rating in 0.1 A
    parameter bit SMALL_RATING = 1'b0, // drive belongs to the small ratings
    parameter int TICK_CYCLES = `MTP_TICK_US * `MTP_CLK_MHZ // cycles per integration step
) (
    input wire logic sys_clk_i, // 200 MHz control clock
    input wire logic rst_b_i, // async reset, active low
    input mtp_pkg::mtp_bus_req_t bus_i, // register port request
    output logic [31:0] rdata_o, // read data, cycle after the read strobe
    input wire logic [6:0] in_term_i, // input terminal levels
    input wire logic [12:0] out_current_i, // measured output current, 0.1 A
    input wire logic [15:0] out_freq_i, // output frequency, 0.01 Hz
    output logic [2:0] out_term_o, // output terminal levels
    output logic thermal_prealarm_out_o, // prealarm signal
    output logic prealarm_indication_o, // prealarm display request
    output logic drive_trip_o, // trip, stop the output stage
    output mtp_pkg::mtp_fault_t fault_code_o, // latched fault code
    output logic second_set_active_o // second parameter set in force
);
    import mtp_pkg::*;

    localparam logic [15:0] RATED1_RESET = SMALL_RATING ?
        16'(32'(DRIVE_RATED_CURRENT) * `MTP_SMALL_PCT / 100) : DRIVE_RATED_CURRENT;
    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

    // ==========================================================
    // settings registers
    logic [15:0] rated1_r;
    logic [15:0] rated2_r;
    logic [15:0] mtype_r;
    logic [15:0] mtype2_r;
    logic [3:0] carrier_r;
    logic [7:0] infn_r [0:6];
    logic [7:0] outfn_r [0:2];

    wire wr_rated1 = bus_i.wr && bus_i.addr == `MTP_REG_RATED1;
    wire wr_rated2 = bus_i.wr && bus_i.addr == `MTP_REG_RATED2;
    wire wr_mtype = bus_i.wr && bus_i.addr == `MTP_REG_MTYPE;
    wire wr_mtype2 = bus_i.wr && bus_i.addr == `MTP_REG_MTYPE2;
    wire wr_carrier = bus_i.wr && bus_i.addr == `MTP_REG_CARRIER;
    wire wr_infn_lo = bus_i.wr && bus_i.addr == `MTP_REG_INFN_LO;
    wire wr_infn_hi = bus_i.wr && bus_i.addr == `MTP_REG_INFN_HI;
    wire wr_outfn = bus_i.wr && bus_i.addr == `MTP_REG_OUTFN;
    wire [15:0] wval = bus_i.wdata[15:0];
    // out-of-range ratings are refused so the stored value is always legal
    wire rated1_ok = wval <= `MTP_RATED_MAX;
    wire rated2_ok = wval <= `MTP_RATED_MAX || wval == `MTP_SETTING_OFF;

    // software writes; settings persist until reset
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rated1_r <= RATED1_RESET;
            rated2_r <= `MTP_SETTING_OFF;
            mtype_r <= 16'h0000;
            mtype2_r <= `MTP_SETTING_OFF;
            carrier_r <= 4'h0;
        end else begin
            if (wr_rated1 && rated1_ok) rated1_r <= wval;
            if (wr_rated2 && rated2_ok) rated2_r <= wval;
            if (wr_mtype) mtype_r <= wval;
            if (wr_mtype2) mtype2_r <= wval;
            if (wr_carrier) carrier_r <= bus_i.wdata[3:0];
        end
    end

    // terminal function code tables, four codes in the low input word, three in the high input word and the output word
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 7; i++) infn_r[i] <= 8'h00;
            for (int i = 0; i < 3; i++) outfn_r[i] <= 8'h00;
        end else begin
            for (int i = 0; i < 4; i++) if (wr_infn_lo) infn_r[i] <= bus_i.wdata[8*i +: 8];
            for (int i = 0; i < 3; i++) if (wr_infn_hi) infn_r[4+i] <= bus_i.wdata[8*i +: 8];
            for (int i = 0; i < 3; i++) if (wr_outfn) outfn_r[i] <= bus_i.wdata[8*i +: 8];
        end
    end

    // ==========================================================
    // terminal routing
    logic [6:0] sel_hits;
    logic [6:0] ext_hits;
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            sel_hits[i] = in_term_i[i] && infn_r[i] == `MTP_FN_SECOND_SEL;
            ext_hits[i] = in_term_i[i] && infn_r[i] == `MTP_FN_EXT_THERMAL;
        end
    end
    wire second_sel = |sel_hits;
    wire ext_relay = |ext_hits;

    // ==========================================================
    // motor selection, per the validity of each setting
    wire m1_valid = rated1_r != `MTP_RATED_ZERO;
    wire m2_valid = rated2_r != `MTP_RATED_ZERO && rated2_r != `MTP_SETTING_OFF;
    // a disabled second setting leaves motor one in charge even with select on
    wire sel2 = second_sel && rated2_r != `MTP_SETTING_OFF;
    wire m1_hot = m1_valid && !sel2;
    wire m2_hot = m2_valid && second_sel;
    // no second motor type means the first characteristic is used for both
    wire [15:0] act_type = (second_sel && mtype2_r != `MTP_SETTING_OFF) ? mtype2_r : mtype_r;

    function automatic logic is_ct(input logic [15:0] t);
        is_ct = t == 16'h0001 || (t >= 16'h000D && t <= 16'h0010) ||
                t == 16'h0032 || t == 16'h0035 || t == 16'h0036;
    endfunction

    // ==========================================================
    // heat inputs; low speed weighs current up for poor self cooling
    wire [15:0] low_freq = is_ct(act_type) ? `MTP_CT_FREQ : `MTP_STD_FREQ;
    wire low_speed = out_freq_i < low_freq;
    wire [13:0] eff_cur = low_speed ? 14'(out_current_i) + 14'(out_current_i >> 2) : 14'(out_current_i);
    wire [27:0] heat_m = 28'(eff_cur) * 28'(eff_cur);
    wire [27:0] heat_t = 28'(out_current_i) * 28'(out_current_i);
    // unselected valid motor sees zero current and cools down
    wire [27:0] heat1 = m1_hot ? heat_m : 28'h0;
    wire [27:0] heat2 = m2_hot ? heat_m : 28'h0;

    // integration step prescaler
    logic [23:0] tick_cnt_r;
    wire tick = tick_cnt_r == TICK_LAST;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) tick_cnt_r <= 24'h0;
        else tick_cnt_r <= tick ? 24'h0 : tick_cnt_r + 24'h1;
    end

    logic [27:0] acc1;
    logic [27:0] acc2;
    logic [27:0] acct;

    mtp_heat_acc u_acc_motor1 (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(tick),
        .enable_i(m1_valid),
        .heat_i(heat1),
        .acc_o(acc1)
    );

    mtp_heat_acc u_acc_motor2 (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(tick),
        .enable_i(m2_valid),
        .heat_i(heat2),
        .acc_o(acc2)
    );

    // output stage protection runs even when motor protection is off
    mtp_heat_acc u_acc_transistor (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(tick),
        .enable_i(1'b1),
        .heat_i(heat_t),
        .acc_o(acct)
    );

    // ==========================================================
    // level comparisons against the applicable rating
    wire [27:0] act_acc = sel2 ? acc2 : acc1;
    wire [15:0] act_rated = sel2 ? rated2_r : rated1_r;
    wire act_valid = sel2 ? m2_valid : m1_valid;
    wire [39:0] acc_pct = 40'(act_acc) * 40'h64;
    wire [39:0] rated_sq = 40'(act_rated) * 40'(act_rated);
    wire pre_hit = act_valid && acc_pct >= rated_sq * 40'(`MTP_PREALARM_PCT);
    wire ovl_hit = act_valid && acc_pct >= rated_sq * 40'(`MTP_TRIP_PCT);
    // output stage limit is 150 percent of the rating squared, lowered by 1/16 of the rating squared per carrier step
    wire [39:0] drv_sq = 40'(DRIVE_RATED_CURRENT) * 40'(DRIVE_RATED_CURRENT);
    wire [39:0] tr_limit = drv_sq + (drv_sq >> 1) - (drv_sq >> 4) * 40'(carrier_r);
    wire tr_hit = 40'(acct) >= tr_limit;

    // first fault wins; nothing but reset releases it
    wire fault_free = fault_code_o == MTP_FAULT_NONE;
    mtp_fault_t fault_nxt;
    assign fault_nxt = !fault_free ? fault_code_o :
                       ext_relay ? MTP_FAULT_EXTERNAL_THERMAL :
                       ovl_hit ? MTP_FAULT_MOTOR_OVERLOAD :
                       tr_hit ? MTP_FAULT_TRANSISTOR_OVERHEAT : MTP_FAULT_NONE;

    // ==========================================================
    // output terminal mapping; unassigned terminals idle low
    logic [2:0] out_term_nxt;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            out_term_nxt[i] = (outfn_r[i] == `MTP_FN_PREALARM_POS && pre_hit) ||
                              (outfn_r[i] == `MTP_FN_PREALARM_NEG && !pre_hit);
        end
    end

    // status outputs; prealarm feeds no trip path at all
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fault_code_o <= MTP_FAULT_NONE;
            drive_trip_o <= 1'b0;
            thermal_prealarm_out_o <= 1'b0;
            prealarm_indication_o <= 1'b0;
            out_term_o <= 3'h0;
            second_set_active_o <= 1'b0;
        end else begin
            fault_code_o <= fault_nxt;
            drive_trip_o <= fault_nxt != MTP_FAULT_NONE;
            thermal_prealarm_out_o <= pre_hit;
            prealarm_indication_o <= pre_hit;
            out_term_o <= out_term_nxt;
            second_set_active_o <= second_sel;
        end
    end

    // ==========================================================
    // read path; unmapped addresses read zero
    logic [31:0] status_word;
    assign status_word = {26'h0, fault_code_o, second_set_active_o, sel2, drive_trip_o,
                          thermal_prealarm_out_o};
    logic [31:0] rd_mux;
    always_comb begin
        unique case (bus_i.addr)
            `MTP_REG_RATED1: rd_mux = {16'h0, rated1_r};
            `MTP_REG_RATED2: rd_mux = {16'h0, rated2_r};
            `MTP_REG_MTYPE: rd_mux = {16'h0, mtype_r};
            `MTP_REG_MTYPE2: rd_mux = {16'h0, mtype2_r};
            `MTP_REG_CARRIER: rd_mux = {28'h0, carrier_r};
            `MTP_REG_INFN_LO: rd_mux = {infn_r[3], infn_r[2], infn_r[1], infn_r[0]};
            `MTP_REG_INFN_HI: rd_mux = {8'h0, infn_r[6], infn_r[5], infn_r[4]};
            `MTP_REG_OUTFN: rd_mux = {8'h0, outfn_r[2], outfn_r[1], outfn_r[0]};
            `MTP_REG_STATUS: rd_mux = status_word;
            `MTP_REG_ACC1: rd_mux = {4'h0, acc1};
            `MTP_REG_ACC2: rd_mux = {4'h0, acc2};
            `MTP_REG_ACCT: rd_mux = {4'h0, acct};
            default: rd_mux = 32'h0;
        endcase
    end

    // data stands for one cycle only, zero otherwise
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) rdata_o <= 32'h0;
        else rdata_o <= bus_i.rd ? rd_mux : 32'h0;
    end
endmodule // mtp_thermal_protect

// ### inc/mtp_consts.svh
// constants of the motor thermal overload protection block
// assumes includers use the macros only; no logic lives here
`ifndef MTP_CONSTS_SVH
`define MTP_CONSTS_SVH

// ==========================================================
// register byte addresses
`define MTP_REG_RATED1 8'h00
`define MTP_REG_RATED2 8'h04
`define MTP_REG_MTYPE 8'h08
`define MTP_REG_MTYPE2 8'h0C
`define MTP_REG_CARRIER 8'h10
`define MTP_REG_INFN_LO 8'h14
`define MTP_REG_INFN_HI 8'h18
`define MTP_REG_OUTFN 8'h1C
`define MTP_REG_STATUS 8'h20
`define MTP_REG_ACC1 8'h24
`define MTP_REG_ACC2 8'h28
`define MTP_REG_ACCT 8'h2C

// ==========================================================
// settings, currents in 0.1 A, frequencies in 0.01 Hz
`define MTP_RATED_MAX 16'h1388
`define MTP_SETTING_OFF 16'h270F
`define MTP_RATED_ZERO 16'h0000
`define MTP_SMALL_PCT 85
`define MTP_PREALARM_PCT 85
`define MTP_TRIP_PCT 100
`define MTP_CT_FREQ 16'h0258
`define MTP_STD_FREQ 16'h0BB8
`define MTP_FN_SECOND_SEL 8'h03
`define MTP_FN_EXT_THERMAL 8'h07
`define MTP_FN_PREALARM_POS 8'h08
`define MTP_FN_PREALARM_NEG 8'h6C

// ==========================================================
// timing
`define MTP_CLK_MHZ 200
`define MTP_TICK_US 1000
`define MTP_LEAK_SHIFT 8

// ==========================================================
// status register bits
`define MTP_ST_PREALARM 0
`define MTP_ST_TRIP 1
`define MTP_ST_SEL2 2
`define MTP_ST_SECOND_SET 3
`define MTP_ST_FAULT_LSB 4

`endif

// ### inc/mtp_pkg.sv
// types shared by the motor thermal overload protection block
// assumes nothing beyond a synthesis tool that reads packages
package mtp_pkg;

    // ==========================================================
    // latched fault codes
    typedef enum logic [1:0] {
        MTP_FAULT_NONE,
        MTP_FAULT_MOTOR_OVERLOAD,
        MTP_FAULT_TRANSISTOR_OVERHEAT,
        MTP_FAULT_EXTERNAL_THERMAL
    } mtp_fault_t;

    // ==========================================================
    // register port request, strobes one cycle long
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } mtp_bus_req_t;

endpackage

// ### tb/mtp_motor_model.sv
// motor with its external thermal relay, behind the drive output
// assumes the bench sets the load and the winding temperature
`timescale 1ns/100ps

// ==========================================================
// behavioural partner
module mtp_motor_model #(
    parameter int RELAY_DELAY = 3 // cycles of overheating counted before the contact closes on the next edge
) (
    input wire logic sys_clk_i, // control clock
    input wire logic rst_b_i, // reset, active low
    input wire logic [12:0] load_i, // current the load draws, 0.1 A
    input wire logic hot_i, // winding over temperature
    input wire logic drive_trip_i, // drive output stopped
    output logic [12:0] current_o, // measured output current
    output logic relay_o // thermal contact, high when operated
);
    int heat_cnt;
    // relay is slow on purpose; current collapses as soon as the output stops
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            current_o <= 13'h0000;
            relay_o <= 1'b0;
            heat_cnt <= 0;
        end else begin
            current_o <= drive_trip_i ? 13'h0000 : (load_i > 13'h1388 ? 13'h1388 : load_i);
            heat_cnt <= hot_i ? heat_cnt + 1 : 0;
            relay_o <= hot_i && heat_cnt >= RELAY_DELAY;
        end
    end
endmodule // mtp_motor_model

// ### tb/mtp_thermal_protect_assertions.sv
// port-level checker for the motor thermal protection top
// assumes outputs are low at reset and a latched fault holds until reset
`timescale 1ns/100ps
`include "mtp_consts.svh"

// ==========================================================
// checker
module mtp_checker (
    input wire logic sys_clk_i, // control clock
    input wire logic rst_b_i, // async reset, active low
    input mtp_pkg::mtp_bus_req_t bus_i, // register request
    input wire logic [31:0] rdata_o, // read data
    input wire logic [6:0] in_term_i, // input terminals
    input wire logic [12:0] out_current_i, // output current
    input wire logic [15:0] out_freq_i, // output frequency
    input wire logic [2:0] out_term_o, // output terminals
    input wire logic thermal_prealarm_out_o, // prealarm
    input wire logic prealarm_indication_o, // prealarm display
    input wire logic drive_trip_o, // trip
    input mtp_pkg::mtp_fault_t fault_code_o, // latched fault
    input wire logic second_set_active_o // second set in force
);
    import mtp_pkg::*;
    logic [15:0] infn_r; // codes of terminals 0 and 1
    // shadow of the low input codes, so terminal rules can be judged from the ports alone
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            infn_r <= 16'h0000;
        end else if (bus_i.wr && bus_i.addr == `MTP_REG_INFN_LO) begin
            infn_r <= bus_i.wdata[15:0];
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    trip_latch_a: assert property (drive_trip_o |=> drive_trip_o)
        else $error("trip released without reset");
    fault_hold_a: assert property (fault_code_o != MTP_FAULT_NONE |=> $stable(fault_code_o))
        else $error("latched fault code changed");
    trip_code_a: assert property (drive_trip_o == (fault_code_o != MTP_FAULT_NONE))
        else $error("trip and fault code disagree");
    ind_follow_a: assert property (prealarm_indication_o == thermal_prealarm_out_o)
        else $error("prealarm display differs from prealarm");
    reset_clear_a: assert property ($rose(rst_b_i) |-> !thermal_prealarm_out_o && !drive_trip_o)
        else $error("outputs not clear after reset");
    rdata_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0000_0000)
        else $error("read data outside its cycle");
    sel_follow_a: assert property (in_term_i[0] && infn_r[7:0] == `MTP_FN_SECOND_SEL |=> second_set_active_o)
        else $error("second set not taken from select terminal");
    relay_trip_a: assert property (in_term_i[1] && infn_r[15:8] == `MTP_FN_EXT_THERMAL
        && fault_code_o == MTP_FAULT_NONE |=> fault_code_o == MTP_FAULT_EXTERNAL_THERMAL && drive_trip_o)
        else $error("external relay did not trip");
    cover property ($rose(thermal_prealarm_out_o));
    cover property ($rose(drive_trip_o) && fault_code_o == MTP_FAULT_MOTOR_OVERLOAD);
    cover property ($rose(drive_trip_o) && fault_code_o == MTP_FAULT_EXTERNAL_THERMAL);
endmodule // mtp_checker

bind mtp_thermal_protect mtp_checker mtp_checker_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .in_term_i(in_term_i), .out_current_i(out_current_i), .out_freq_i(out_freq_i),
    .out_term_o(out_term_o), .thermal_prealarm_out_o(thermal_prealarm_out_o),
    .prealarm_indication_o(prealarm_indication_o), .drive_trip_o(drive_trip_o), .fault_code_o(fault_code_o),
    .second_set_active_o(second_set_active_o));

// ### tb/tb_mtp_thermal_protect.sv
// self-checking bench for the motor thermal protection block
// assumes a shortened integration step and the motor model on the far side
`timescale 1ns/100ps
`include "mtp_consts.svh"

// ==========================================================
// bench top
module tb_mtp_thermal_protect;
    import mtp_pkg::*;
    logic sys_clk_i;
    logic rst_b_i;
    mtp_bus_req_t bus_r;
    logic [31:0] rdata_w, lfsr_r, exp_q[$];
    logic [6:0] term_r, in_term_w;
    logic [12:0] load_r, cur_w;
    logic [15:0] freq_r, fbase_r;
    logic [2:0] out_term_w;
    logic hot_r, relay_w, rd_seen_r, pre_w, ind_w, trip_w, sec_w;
    mtp_fault_t fault_w;
    int n_mismatch, total_checks, n;
    assign in_term_w = {term_r[6:2], relay_w, term_r[0]};
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    mtp_thermal_protect #(.TICK_CYCLES(4)) mtp_thermal_protect_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .bus_i(bus_r), .rdata_o(rdata_w), .in_term_i(in_term_w), .out_current_i(cur_w), .out_freq_i(freq_r),
        .out_term_o(out_term_w), .thermal_prealarm_out_o(pre_w), .prealarm_indication_o(ind_w),
        .drive_trip_o(trip_w), .fault_code_o(fault_w), .second_set_active_o(sec_w));
    mtp_motor_model mtp_motor_model_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .load_i(load_r),
        .hot_i(hot_r), .drive_trip_i(trip_w), .current_o(cur_w), .relay_o(relay_w));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // random frequency rides above a band base; the default base keeps it at 30 Hz or more,
    // so low-speed weighting stays out of the sums unless a scenario lowers the base
    always @(posedge sys_clk_i) begin
        lfsr_r <= rst_b_i ? lfsr_next(lfsr_r) : 32'h6A8A;
        freq_r <= fbase_r + {7'h00, lfsr_r[8:0]};
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        total_checks++;
        if (got !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        bus_r <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i);
        bus_r.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        bus_r <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        bus_r.rd <= 1'b0;
    endtask
    // bounded wait on prealarm or trip, sampled at the falling edge where outputs are settled
    task automatic wait_for(input bit on_trip, input int lim);
        n = 0;
        while ((on_trip ? trip_w : pre_w) !== 1'b1 && n < lim) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk("wait_done", 32'h1, {31'h0, n < lim});
    endtask
    // read data stand only in the cycle after the strobe, so compare exactly there
    always @(posedge sys_clk_i) begin
        rd_seen_r <= bus_r.rd;
        if (rd_seen_r === 1'b1) begin
            chk("rdata", exp_q.pop_front(), rdata_w);
        end
    end
    // reset pulse of three edges, released by a non-blocking assignment on a rising edge
    task automatic pulse_reset();
        @(posedge sys_clk_i);
        rst_b_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge sys_clk_i);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        rst_b_i = 1'b0;
        bus_r = '0;
        term_r = 7'h00;
        load_r = 13'h0000;
        hot_r = 1'b0;
        fbase_r = 16'h0BB8;
        repeat (8) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rd(`MTP_REG_RATED1, 32'h0000_00A0);
        rd(`MTP_REG_RATED2, 32'h0000_270F);
        rd(8'h30, 32'h0000_0000);
        wr(`MTP_REG_RATED1, 32'h0000_1389);
        rd(`MTP_REG_RATED1, 32'h0000_00A0);
        wr(`MTP_REG_RATED1, 32'h0000_1388);
        rd(`MTP_REG_RATED1, 32'h0000_1388);
        wr(`MTP_REG_RATED2, 32'h0000_1389);
        rd(`MTP_REG_RATED2, 32'h0000_270F);
        // select on while the second setting is off: motor one keeps the load
        wr(`MTP_REG_INFN_LO, 32'h0000_0703);
        wr(`MTP_REG_OUTFN, 32'h0000_6C08);
        wr(`MTP_REG_RATED1, 32'h0000_0064);
        term_r <= 7'h01;
        load_r <= 13'h00C8;
        repeat (40) @(posedge sys_clk_i);
        rd(`MTP_REG_STATUS, 32'h0000_0008);
        chk("second_set", 32'h1, {31'h0, sec_w});
        rd(`MTP_REG_ACC2, 32'h0000_0000);
        chk("out_term", 32'h2, {29'h0, out_term_w});
        wr(`MTP_REG_RATED2, 32'h0000_00C8);
        rd(`MTP_REG_STATUS, 32'h0000_000C);
        repeat (200) @(posedge sys_clk_i);
        term_r <= 7'h00;
        wait_for(1'b0, 3000);
        chk("trip_at_prealarm", 32'h0, {31'h0, trip_w});
        chk("indication", 32'h1, {31'h0, ind_w});
        repeat (2) @(negedge sys_clk_i);
        chk("out_term", 32'h1, {29'h0, out_term_w});
        wait_for(1'b1, 2000);
        chk("fault", {30'h0, MTP_FAULT_MOTOR_OVERLOAD}, {30'h0, fault_w});
        hot_r <= 1'b1;
        repeat (20) @(negedge sys_clk_i);
        chk("fault_kept", {30'h0, MTP_FAULT_MOTOR_OVERLOAD}, {30'h0, fault_w});
        hot_r <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        pulse_reset();
        @(negedge sys_clk_i);
        chk("trip_after_reset", 32'h0, {31'h0, trip_w | pre_w});
        rd(`MTP_REG_INFN_LO, 32'h0000_0000);
        // rated current zero: heavy load must not integrate or trip
        wr(`MTP_REG_INFN_LO, 32'h0000_0703);
        wr(`MTP_REG_RATED1, 32'h0000_0000);
        repeat (400) @(posedge sys_clk_i);
        rd(`MTP_REG_ACC1, 32'h0000_0000);
        chk("trip_disabled", 32'h0, {31'h0, trip_w});
        hot_r <= 1'b1;
        wait_for(1'b1, 30);
        chk("fault", {30'h0, MTP_FAULT_EXTERNAL_THERMAL}, {30'h0, fault_w});
        hot_r <= 1'b0;
        repeat (10) @(negedge sys_clk_i);
        chk("fault_kept", {30'h0, MTP_FAULT_EXTERNAL_THERMAL}, {30'h0, fault_w});
        // constant-torque motor at 10-15 Hz: no low-speed weighting, so rated load never trips;
        // select on with no second motor type keeps the first characteristic in force
        fbase_r <= 16'h03E8;
        pulse_reset();
        wr(`MTP_REG_INFN_LO, 32'h0000_0003);
        term_r <= 7'h01;
        // dual-rated motor at 60 Hz base: 1.1 times an 18.2 A rating gives 20.0 A
        wr(`MTP_REG_RATED1, 32'h0000_00C8);
        wr(`MTP_REG_MTYPE, 32'h0000_0001);
        repeat (1200) @(posedge sys_clk_i);
        chk("trip_ct_mid", 32'h0, {31'h0, trip_w});
        // below 6 Hz the weighted heat must carry the same load over the trip level
        fbase_r <= 16'h0000;
        wait_for(1'b1, 1000);
        chk("fault", {30'h0, MTP_FAULT_MOTOR_OVERLOAD}, {30'h0, fault_w});
        // motor protection off, highest carrier: output stage must trip well before the carrier 0 time
        fbase_r <= 16'h0BB8;
        pulse_reset();
        wr(`MTP_REG_RATED1, 32'h0000_0000);
        wr(`MTP_REG_CARRIER, 32'h0000_000F);
        rd(`MTP_REG_CARRIER, 32'h0000_000F);
        wait_for(1'b1, 1000);
        chk("fault", {30'h0, MTP_FAULT_TRANSISTOR_OVERHEAT}, {30'h0, fault_w});
        tally_and_finish();
    end
endmodule // tb_mtp_thermal_protect
